// file: verilog/timer_pkg.sv
// shared constants, register indices and carrier types of the one-shot timer
package timer_pkg;
  // timing: system clock, slow oscillator and counting step
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned OSC_KHZ      = 20;
  localparam int unsigned STEP_MS      = 1;
  localparam int unsigned OSC_DIV      = CLK_HZ / (OSC_KHZ * 1000);
  localparam int unsigned OSC_PER_STEP = OSC_KHZ * STEP_MS;
  localparam int unsigned DIV_W        = 16;

  // counter geometry
  localparam int unsigned CNT_W        = 16;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_WRAP     = 16'hFFFF;
  localparam logic [15:0] CNT_ONE      = 16'h0001;

  // bus geometry; byte address is four times the register index
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned IDX_W        = 10;
  localparam int unsigned DATA_W       = 32;

  // register indices
  localparam logic [9:0] IRQ_SUMMARY_STATUS_IDX   = 10'h010;
  localparam logic [9:0] IRQ_ENABLE_IDX           = 10'h014;
  localparam logic [9:0] IRQ_CLEAR_IDX            = 10'h015;
  localparam logic [9:0] TIMER_RELOAD_REG_IDX     = 10'h0A0;
  localparam logic [9:0] TIMER_IRQ_SOURCE_REG_IDX = 10'h0A2;
  localparam logic [9:0] TIMER_CONTROL_REG_IDX    = 10'h0A3;
  localparam logic [9:0] TIMER_COUNT_REG_IDX      = 10'h0A4;

  // field positions
  localparam int unsigned CTL_ENABLE_BIT    = 0;
  localparam int unsigned CTL_LOAD_BIT      = 1;
  localparam int unsigned CTL_AUTO_STOP_BIT = 2;
  localparam int unsigned SRC_UNDERFLOW_BIT = 0;
  localparam int unsigned SUMMARY_TIMER_BIT = 14;

  // values after reset
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

  // one bus request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  // software-visible control state
  typedef struct packed {
    logic enable;
    logic auto_stop_on_wrap;
  } timer_ctl_t;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge
endpackage : timer_pkg

// file: verilog/tick_divider.sv
// enable-pulse divider: one output pulse per DIV input pulses
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic step_in,
  output logic      tick
);
  localparam logic [15:0] LAST = 16'(DIV - 1);

  logic [15:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;

  // count input pulses, emit one pulse on the last
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (step_in) begin
      if (cnt_q == LAST) begin
        cnt_d  = 16'h0000;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : tick_divider

// file: verilog/wrap_counter.sv
// 16-bit one-shot down counter with load, halt and auto-stop sequencing
`timescale 1ns/10ps
module wrap_counter (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        step,
  input  wire logic        load,
  input  wire logic [15:0] reload,
  input  wire logic        enable,
  input  wire logic        auto_stop,
  input  wire logic        rearm,
  output logic [15:0]      count,
  output logic             wrap_set,
  output logic             hw_disable,
  output logic             stepping
);
  logic [15:0] count_q, count_d;
  logic        halt_q, halt_d;
  logic        pend_q, pend_d;

  // load beats rearm beats stepping; a wrap halts until reloaded or re-enabled
  always_comb begin
    count_d    = count_q;
    halt_d     = halt_q;
    pend_d     = 1'b0;
    wrap_set   = pend_q;
    hw_disable = 1'b0;
    stepping   = enable && !halt_q && step && !load && !rearm;
    if (load) begin
      count_d = reload;
      halt_d  = 1'b0;
    end else if (rearm) begin
      halt_d = 1'b0;
    end else if (stepping) begin
      if (count_q == timer_pkg::CNT_ZERO) begin
        count_d = timer_pkg::CNT_WRAP;
        halt_d  = 1'b1;
        if (auto_stop) begin
          hw_disable = 1'b1;
          pend_d     = 1'b1; // flag waits one cycle for enable to drop
        end else begin
          wrap_set = 1'b1;
        end
      end else begin
        count_d = count_q - timer_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= timer_pkg::COUNT_RST;
      halt_q  <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      halt_q  <= halt_d;
      pend_q  <= pend_d;
    end
  end

  assign count = count_q; // held while enable is low and no load arrives
endmodule : wrap_counter

// file: verilog/low_power_oneshot_timer.sv
// top of the one-shot timer: Avalon-MM slave, registers, interrupt and pin
`timescale 1ns/10ps
// Operation
// - The count steps are derived from a 20 kHz rate and held in a 16-bit one-shot down counter.
// - An underflow sets the underflow flag and stops the counting.
// - The timer summary bit stays set exactly as long as the underflow flag is set.
// - The interrupt pin asserts for the timer only when the timer bit of the interrupt enable register is set.
// - Writing one to the load command bit copies the reload value into the counter.
// - While enabled the counter decrements by one every 1 ms.
// - Once enabled the counter keeps decrementing until underflow or until enable is cleared.
// - Underflow is the step from 0x0000 to 0xFFFF.
// - Clearing enable stops counting at once and keeps the count.
// - The count is readable and setting enable again resumes from the held value.
// - With auto-stop set, an underflow clears the enable state and then sets the flag.
// - With auto-stop set, the flag is set only once the timer is fully disabled.
// - One control write setting enable, load and auto-stop loads the reload value and starts counting.
// - Back-to-back writes to reload, source and control are applied one per transfer, in arrival order.
module low_power_oneshot_timer #(
  parameter int unsigned OSC_DIV = timer_pkg::OSC_DIV
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic             irq_pin_out,
  output logic             irq_pin_oe_n
);
  timer_pkg::bus_req_t   req;
  logic [9:0]            idx;
  logic                  fire;
  logic                  wr_reload, wr_source, wr_ctl, wr_en, wr_clr;
  logic [31:0]           merged;
  logic                  load_cmd, rearm;
  logic                  osc_tick, step_tick;
  logic [15:0]           count;
  logic                  wrap_set, hw_disable, stepping;

  logic                  wait_q, wait_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [15:0]           reload_q, reload_d;
  timer_pkg::timer_ctl_t ctl_q, ctl_d;
  logic                  flag_q, flag_d;
  logic                  inten_q, inten_d;
  logic                  flag_clr;
  logic                  irq_q, irq_d;
  logic                  oe_n_q, oe_n_d;
  logic                  pin_q;

  // carry the bus request as one bundle
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 byteenable: avs_byteenable, writedata: avs_writedata};
  assign idx = req.address[11:2];

  // a write takes effect at the edge where waitrequest is seen low
  assign fire      = req.write && !wait_q;
  assign wr_reload = fire && (idx == timer_pkg::TIMER_RELOAD_REG_IDX);
  assign wr_source = fire && (idx == timer_pkg::TIMER_IRQ_SOURCE_REG_IDX);
  assign wr_ctl    = fire && (idx == timer_pkg::TIMER_CONTROL_REG_IDX) && req.byteenable[0];
  assign wr_en     = fire && (idx == timer_pkg::IRQ_ENABLE_IDX) && req.byteenable[1];
  assign wr_clr    = fire && (idx == timer_pkg::IRQ_CLEAR_IDX) && req.byteenable[1];
  assign merged    = timer_pkg::lane_merge({16'h0000, reload_q}, req.writedata, req.byteenable);

  // load is a pulse from the write itself, so the bit never stays set
  assign load_cmd = wr_ctl && req.writedata[timer_pkg::CTL_LOAD_BIT];
  assign rearm    = wr_ctl && req.writedata[timer_pkg::CTL_ENABLE_BIT];

  // 20 kHz pulse from the system clock, then 1 ms step from it
  tick_divider #(
    .DIV (OSC_DIV)
  ) osc_div (
    .clk     (clk),
    .rstn    (rstn),
    .step_in (1'b1),
    .tick    (osc_tick)
  );

  tick_divider #(
    .DIV (timer_pkg::OSC_PER_STEP)
  ) step_div (
    .clk     (clk),
    .rstn    (rstn),
    .step_in (osc_tick),
    .tick    (step_tick)
  );

  // counting core; the enable it sees is the registered control bit
  wrap_counter core (
    .clk        (clk),
    .rstn       (rstn),
    .step       (step_tick),
    .load       (load_cmd),
    .reload     (reload_q),
    .enable     (ctl_q.enable),
    .auto_stop  (ctl_q.auto_stop_on_wrap),
    .rearm      (rearm),
    .count      (count),
    .wrap_set   (wrap_set),
    .hw_disable (hw_disable),
    .stepping   (stepping)
  );

  // bus handshake: one wait cycle, then a single cycle with waitrequest low
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((req.read || req.write) && wait_q) begin
      wait_d = 1'b0;
    end
    if (req.read && wait_q) begin
      rdata_d = timer_pkg::RDATA_RST; // unmapped and reserved read as zero
      case (idx)
        timer_pkg::IRQ_SUMMARY_STATUS_IDX:   rdata_d[timer_pkg::SUMMARY_TIMER_BIT] = flag_q;
        timer_pkg::IRQ_ENABLE_IDX:           rdata_d[timer_pkg::SUMMARY_TIMER_BIT] = inten_q;
        timer_pkg::TIMER_RELOAD_REG_IDX:     rdata_d[15:0] = reload_q;
        timer_pkg::TIMER_IRQ_SOURCE_REG_IDX: rdata_d[timer_pkg::SRC_UNDERFLOW_BIT] = flag_q;
        timer_pkg::TIMER_CONTROL_REG_IDX: begin
          rdata_d[timer_pkg::CTL_ENABLE_BIT]    = ctl_q.enable;
          rdata_d[timer_pkg::CTL_AUTO_STOP_BIT] = ctl_q.auto_stop_on_wrap;
        end
        timer_pkg::TIMER_COUNT_REG_IDX:      rdata_d[15:0] = count;
        default:                             rdata_d = timer_pkg::RDATA_RST;
      endcase
    end
  end

  // register state: writes in arrival order, hardware set beats software clear
  always_comb begin
    reload_d = reload_q;
    ctl_d    = ctl_q;
    inten_d  = inten_q;
    flag_clr = 1'b0;
    if (wr_reload) begin
      reload_d = merged[15:0];
    end
    if (wr_ctl) begin
      ctl_d.enable            = req.writedata[timer_pkg::CTL_ENABLE_BIT];
      ctl_d.auto_stop_on_wrap = req.writedata[timer_pkg::CTL_AUTO_STOP_BIT];
    end
    // a wrap cannot coincide with an enable write, since that write's rearm blocks the step
    if (hw_disable) begin
      ctl_d.enable = 1'b0;
    end
    if (wr_en) begin
      inten_d = req.writedata[timer_pkg::SUMMARY_TIMER_BIT];
    end
    if (wr_source && req.byteenable[0] && req.writedata[timer_pkg::SRC_UNDERFLOW_BIT]) begin
      flag_clr = 1'b1;
    end
    if (wr_clr && req.writedata[timer_pkg::SUMMARY_TIMER_BIT]) begin
      flag_clr = 1'b1;
    end
    flag_d = (flag_q && !flag_clr) || wrap_set;
    irq_d  = flag_q && inten_q;
    oe_n_d = !(flag_q && inten_q); // pin pulled low only while asserting
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_q   <= 1'b1;
      rdata_q  <= timer_pkg::RDATA_RST;
      reload_q <= timer_pkg::RELOAD_RST;
      ctl_q    <= '0;
      flag_q   <= 1'b0;
      inten_q  <= 1'b0;
      irq_q    <= 1'b0;
      oe_n_q   <= 1'b1;
      pin_q    <= 1'b0;
    end else begin
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
      reload_q <= reload_d;
      ctl_q    <= ctl_d;
      flag_q   <= flag_d;
      inten_q  <= inten_d;
      irq_q    <= irq_d;
      oe_n_q   <= oe_n_d;
      pin_q    <= 1'b0;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign irq_pin_out     = pin_q;
  assign irq_pin_oe_n    = oe_n_q;

  // checks on the behaviour above
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence auto_wrap_s;
    stepping && (count == timer_pkg::CNT_ZERO) && ctl_q.auto_stop_on_wrap;
  endsequence

  sequence off_then_flag_s;
    !ctl_q.enable && !flag_q ##1 flag_q;
  endsequence

  load_copy_a: assert property (load_cmd |=> count == $past(reload_q))
    else $error("load command did not copy reload value");

  step_down_a: assert property (stepping && count != timer_pkg::CNT_ZERO |=> count == $past(count) - 16'h0001)
    else $error("counter did not step down by one");

  wrap_value_a: assert property (stepping && count == timer_pkg::CNT_ZERO |=> count == timer_pkg::CNT_WRAP)
    else $error("underflow did not wrap to all ones");

  // the wrap edge itself moves the count to all ones, so the halt is judged from the cycle after
  plain_wrap_a: assert property (stepping && count == timer_pkg::CNT_ZERO && !ctl_q.auto_stop_on_wrap
                                 |=> flag_q && count == timer_pkg::CNT_WRAP ##1 !stepping [*2])
    else $error("plain underflow did not flag and stop");

  auto_off_a: assert property (auto_wrap_s |=> !ctl_q.enable ##1 flag_q)
    else $error("auto stop did not disable then flag");

  auto_order_a: assert property (auto_wrap_s and !flag_q |=> off_then_flag_s)
    else $error("flag set before timer fully disabled");

  halt_hold_a: assert property (!ctl_q.enable && !load_cmd |=> $stable(count))
    else $error("count moved while disabled");

  summary_hold_a: assert property (flag_q && !flag_clr |=> flag_q [*1])
    else $error("summary bit dropped without a clear");

  irq_gate_a: assert property (irq |-> $past(flag_q) && $past(inten_q))
    else $error("interrupt without enabled flag");

  start_all_a: assert property (wr_ctl && req.writedata[2:0] == 3'h7 |=> ctl_q.enable && count == $past(reload_q))
    else $error("combined control write did not load and start");

  bus_answer_a: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle after request");

  load_clear_a: assert property (req.read && wait_q && idx == timer_pkg::TIMER_CONTROL_REG_IDX
                                 |=> !avs_readdata[timer_pkg::CTL_LOAD_BIT])
    else $error("load command bit read back as set");

  // reset state and the flag's set and clear paths
  reset_zero_a: assert property ($rose(rstn) |-> count == timer_pkg::COUNT_RST && !flag_q && !ctl_q.enable
                                 && !ctl_q.auto_stop_on_wrap && reload_q == timer_pkg::RELOAD_RST)
    else $error("timer state not zero after reset");

  wrap_flag_a: assert property (wrap_set |=> flag_q)
    else $error("wrap did not set the underflow flag");

  clear_drop_a: assert property (flag_clr && !wrap_set |=> !flag_q)
    else $error("summary bit stayed after a clear");

  summary_read_a: assert property (req.read && wait_q && idx == timer_pkg::IRQ_SUMMARY_STATUS_IDX
                                   |=> avs_readdata[timer_pkg::SUMMARY_TIMER_BIT] == $past(flag_q))
    else $error("summary bit read back differs from flag");

  // interrupt output and open-drain pin follow the enabled flag one cycle later
  irq_quiet_a: assert property (!(flag_q && inten_q) |=> !irq && irq_pin_oe_n)
    else $error("interrupt or pin active without enabled flag");

  irq_drive_a: assert property (flag_q && inten_q |=> irq && !irq_pin_oe_n && !irq_pin_out)
    else $error("enabled flag did not drive interrupt and pin");

  // held count survives a re-enable and reads back as it stood
  rearm_hold_a: assert property (rearm && !load_cmd |=> count == $past(count))
    else $error("re-enable moved the held count");

  count_read_a: assert property (req.read && wait_q && idx == timer_pkg::TIMER_COUNT_REG_IDX
                                 |=> avs_readdata[15:0] == $past(count))
    else $error("count read back differs from counter");

  // each accepted write lands at its answer edge
  reload_write_a: assert property (wr_reload && req.byteenable[1:0] == 2'h3
                                   |=> reload_q == $past(req.writedata[15:0]))
    else $error("reload write did not land");

  ctl_write_a: assert property (wr_ctl && !hw_disable
                                |=> ctl_q.enable == $past(req.writedata[timer_pkg::CTL_ENABLE_BIT]))
    else $error("control write did not land");
endmodule : low_power_oneshot_timer

// file: tb/low_power_oneshot_timer_tb_top.sv
// self-checking bench of the one-shot timer, driven over its register bus
`timescale 1ns/10ps
module low_power_oneshot_timer_tb_top;
  localparam int unsigned DIV = 2;  // small divider: one count step every 40 clocks
  logic        clk;
  logic        rstn;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        irq_pin_out;
  logic        irq_pin_oe_n;
  int          bad_count;
  int          n_tests;
  logic [31:0] q;
  logic [31:0] v1;
  int          n;

  low_power_oneshot_timer #(.OSC_DIV(DIV)) DUT (
    .clk             (clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .irq_pin_out     (irq_pin_out),
    .irq_pin_oe_n    (irq_pin_oe_n)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  // byte addresses are four times the register index
  localparam logic [11:0] A_SUM = 12'h040;
  localparam logic [11:0] A_IEN = 12'h050;
  localparam logic [11:0] A_ICL = 12'h054;
  localparam logic [11:0] A_RLD = 12'h280;
  localparam logic [11:0] A_SRC = 12'h288;
  localparam logic [11:0] A_CTL = 12'h28C;
  localparam logic [11:0] A_CNT = 12'h290;
  localparam logic [11:0] A_BAD = 12'h3FC;

  // one bus transfer: raised after a rising edge, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq);
    int k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("[FAIL] t=%0t waitrequest got=%h exp=%h", $time, avs_waitrequest, 1'b0);
    end
    // data taken and request released at the same answering edge
    rq = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 32'h0000_0000, got);
    chk(got, exp);
  endtask : rd_chk

  // counts mid-cycle samples until irq is seen high, bounded
  task automatic wait_irq(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (irq !== 1'b1 && cyc < 400);
  endtask : wait_irq

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // hang guard: the sequence needs about 1100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // values after reset, unmapped place reads zero and ignores writes
    chk({30'h0, irq, irq_pin_oe_n}, 32'h0000_0001);
    rd_chk(A_RLD, 32'h0000_0000);
    rd_chk(A_CNT, 32'h0000_0000);
    rd_chk(A_CTL, 32'h0000_0000);
    rd_chk(A_SRC, 32'h0000_0000);
    rd_chk(A_SUM, 32'h0000_0000);
    wr(A_BAD, 32'hFFFF_FFFF);
    rd_chk(A_BAD, 32'h0000_0000);
    $display("test reset done");
    // load without enable, then halt and resume
    wr(A_RLD, 32'h0000_0100);
    wr(A_CTL, 32'h0000_0002);
    rd_chk(A_CNT, 32'h0000_0100);
    rd_chk(A_CTL, 32'h0000_0000);
    wr(A_CTL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    wr(A_CTL, 32'h0000_0000);
    bus(1'b0, A_CNT, 32'h0000_0000, v1);
    chk({31'h0, (v1 == 32'h0FE || v1 == 32'h0FD)}, 32'h0000_0001);
    repeat (200) @(posedge clk);
    rd_chk(A_CNT, v1);
    wr(A_CTL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    wr(A_CTL, 32'h0000_0000);
    bus(1'b0, A_CNT, 32'h0000_0000, q);
    chk({31'h0, (v1 - q == 32'h2 || v1 - q == 32'h3)}, 32'h0000_0001);
    $display("test halt and resume done");
    // auto-stop underflow with one control write
    wr(A_IEN, 32'h0000_4000);
    wr(A_RLD, 32'h0000_0002);
    wr(A_CTL, 32'h0000_0007);
    wait_irq(n);
    chk({31'h0, (n >= 82 && n <= 123)}, 32'h0000_0001);
    chk({30'h0, irq_pin_out, irq_pin_oe_n}, 32'h0000_0000);
    rd_chk(A_CNT, 32'h0000_FFFF);
    rd_chk(A_CTL, 32'h0000_0004);
    rd_chk(A_SRC, 32'h0000_0001);
    rd_chk(A_SUM, 32'h0000_4000);
    repeat (120) @(posedge clk);
    rd_chk(A_CNT, 32'h0000_FFFF);
    $display("test auto stop done");
    // reload, clear and restart as back-to-back writes in address order
    wr(A_RLD, 32'h0000_0001);
    wr(A_SRC, 32'h0000_0001);
    wr(A_CTL, 32'h0000_0007);
    rd_chk(A_SUM, 32'h0000_0000);
    wait_irq(n);
    chk({31'h0, (n >= 30 && n <= 90)}, 32'h0000_0001);
    rd_chk(A_SUM, 32'h0000_4000);
    $display("test burst restart done");
    // masking and clearing through the summary side
    wr(A_IEN, 32'h0000_0000);
    repeat (3) @(negedge clk);
    chk({30'h0, irq, irq_pin_oe_n}, 32'h0000_0001);
    rd_chk(A_SUM, 32'h0000_4000);
    wr(A_IEN, 32'h0000_4000);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(A_ICL, 32'h0000_4000);
    repeat (3) @(negedge clk);
    chk({30'h0, irq, irq_pin_oe_n}, 32'h0000_0001);
    rd_chk(A_SRC, 32'h0000_0000);
    $display("test mask and clear done");
    // no auto-stop: still one-shot, enable bit stays set
    wr(A_RLD, 32'h0000_0001);
    wr(A_CTL, 32'h0000_0003);
    wait_irq(n);
    chk({31'h0, (n >= 40 && n <= 90)}, 32'h0000_0001);
    rd_chk(A_CTL, 32'h0000_0001);
    repeat (120) @(posedge clk);
    rd_chk(A_CNT, 32'h0000_FFFF);
    rd_chk(A_SRC, 32'h0000_0001);
    $display("test plain one-shot done");
    // byte lanes: reload keeps disabled lanes, control ignores a write without lane 0
    avs_byteenable <= 4'h1;
    wr(A_RLD, 32'h0000_ABCD);
    avs_byteenable <= 4'h2;
    wr(A_CTL, 32'h0000_0006);
    avs_byteenable <= 4'hF;
    rd_chk(A_RLD, 32'h0000_00CD);
    rd_chk(A_CTL, 32'h0000_0001);
    rd_chk(A_CNT, 32'h0000_FFFF);
    $display("test byte lanes done");
    // reset in mid-run, with flag and interrupt active, clears all timer state
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({30'h0, irq, irq_pin_oe_n}, 32'h0000_0001);
    rd_chk(A_CNT, 32'h0000_0000);
    rd_chk(A_SRC, 32'h0000_0000);
    rd_chk(A_CTL, 32'h0000_0000);
    rd_chk(A_RLD, 32'h0000_0000);
    rd_chk(A_IEN, 32'h0000_0000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : low_power_oneshot_timer_tb_top
